// [hdl/hook_debounce.sv]
/*
  Hookswitch pin conditioning: synchroniser, glitch filter and debounce.
  Assumes an asynchronous pin and the system clock.
*/
module hook_debounce
  import line_ctrl_pkg::*;
#(
  parameter int GLITCH   = GLITCH_CYC,
  parameter int DEBOUNCE = DEBOUNCE_CYC
)
(
  // Clock and reset
  input  wire logic clock,
  input  wire logic resetn,
  // Pin
  input  wire logic hookPin,
  // Conditioned level and change pulse
  output logic      hookLevel,
  output logic      hookChange
);

  typedef struct packed {
    logic        s1;
    logic        s2;
    logic [1:0]  prime;
    logic        filt;
    logic [7:0]  gCnt;
    logic [23:0] dCnt;
    logic        level;
    logic        change;
  } hook_s;

  hook_s st_r;
  hook_s st_nxt;

  always_comb
  begin
    st_nxt        = st_r;
    st_nxt.s1     = hookPin;
    st_nxt.s2     = st_r.s1;
    st_nxt.change = 1'b0;
    if (st_r.prime != 2'h3)
    begin
      // Take the pin level at start-up without a change event
      st_nxt.prime = st_r.prime + 2'h1;
      st_nxt.filt  = st_r.s2;
      st_nxt.level = st_r.s2;
    end
    else
    begin
      // Short pulses never reach the filtered level
      if (st_r.s2 == st_r.filt)
        st_nxt.gCnt = 8'h00;
      else if (st_r.gCnt >= 8'(GLITCH - 1))
      begin
        st_nxt.filt = st_r.s2;
        st_nxt.gCnt = 8'h00;
      end
      else
        st_nxt.gCnt = st_r.gCnt + 8'h01;
      if (st_r.filt == st_r.level)
        st_nxt.dCnt = 24'h000000;
      else if (st_r.dCnt >= 24'(DEBOUNCE - 1))
      begin
        st_nxt.level  = st_r.filt;
        st_nxt.change = 1'b1;
        st_nxt.dCnt   = 24'h000000;
      end
      else
        st_nxt.dCnt = st_r.dCnt + 24'h000001;
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign hookLevel  = st_r.level;
  assign hookChange = st_r.change;

endmodule : hook_debounce

// [hdl/line_ctrl_pkg.sv]
/*
  Shared constants and carrier types of the S/T line control register bank.
  Assumes one 50 MHz system clock and an 8-bit indirect register port.
*/
package line_ctrl_pkg;

  // Register offsets and reset value
  localparam logic [7:0] LINE_STATUS_ADDR = 8'ha1;
  localparam logic [7:0] D_PRIORITY_ADDR  = 8'ha2;
  localparam logic [7:0] LINE_MODE1_ADDR  = 8'ha3;
  localparam logic [7:0] LINE_MODE2_ADDR  = 8'ha4;
  localparam logic [7:0] MULTIFRAME_ADDR  = 8'ha6;
  localparam logic [7:0] REG_RESET_VAL    = 8'h00;

  // Status bits
  localparam int ST_F3_CHG   = 3;
  localparam int ST_F7_CHG   = 4;
  localparam int ST_F8_CHG   = 5;
  localparam int ST_HOOK     = 6;
  localparam int ST_HOOK_CHG = 7;

  // Mode one bits
  localparam int M1_B1_TX   = 0;
  localparam int M1_B2_TX   = 1;
  localparam int M1_F_DIS   = 2;
  localparam int M1_FA_DIS  = 3;
  localparam int M1_ACT_REQ = 4;
  localparam int M1_F8_F3   = 5;
  localparam int M1_ENABLE  = 6;

  // Mode two bits
  localparam int M2_LOC_LOOP  = 0;
  localparam int M2_LINE_LOOP = 1;
  localparam int M2_NO_BACK   = 2;
  localparam int M2_IE_F3     = 3;
  localparam int M2_IE_F8     = 4;
  localparam int M2_IE_HOOK   = 5;
  localparam int M2_IE_F7     = 6;

  // Multiframe bits
  localparam int MULTI_ENABLE = 0;
  localparam int MULTI_FIRST  = 4;
  localparam int MULTI_SYNC   = 7;

  // Activation state codes
  localparam logic [2:0] ACT_F2 = 3'h0;
  localparam logic [2:0] ACT_F3 = 3'h1;
  localparam logic [2:0] ACT_F6 = 3'h4;
  localparam logic [2:0] ACT_F7 = 3'h5;
  localparam logic [2:0] ACT_F8 = 3'h6;

  // D-channel access and multiframe counts
  localparam logic [5:0] ONES_BASE        = 6'h08;
  localparam logic [5:0] ONES_STEP        = 6'h02;
  localparam logic [1:0] MULTI_LOST_COUNT = 2'h3;

  // Hookswitch timing
  localparam int CLOCK_PERIOD_NS = 20;
  localparam int GLITCH_NS       = 162;
  localparam int DEBOUNCE_MS     = 16;
  localparam int GLITCH_CYC      = (GLITCH_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int DEBOUNCE_CYC    = (DEBOUNCE_MS * 1000000) / CLOCK_PERIOD_NS;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic       wrStb;
    logic       rdStb;
  } reg_req_s;

  typedef struct packed {
    logic strobe;
    logic echoBit;
    logic txBit;
    logic txActive;
    logic txDone;
    logic lineRxD;
    logic procTxD;
  } d_chan_in_s;

  typedef struct packed {
    logic b1TxEn;
    logic b2TxEn;
    logic fTxDis;
    logic faTxDis;
    logic actRequest;
    logic goF8ToF3;
    logic lineEnable;
  } line_ctl_s;

endpackage : line_ctrl_pkg

// [hdl/s_interface_line_ctrl_regs.sv]
/*
  Control and status register bank of an S/T line interface: activation
  status, hookswitch, D-channel priority stepping, loopbacks, multiframe.
  Assumes the activation state machine, link controller and multiframe
  receiver run on the same clock; the hookswitch is an asynchronous pin.
*/
// Notes on behaviour
// - Status bits 2..0 show activation state, F2 as 000 through F8 as 110.
// - Reading status clears bits 3, 4, 5 and 7; other bits stay live.
// - Status latches F3 entry, F7 change, F8 change and hookswitch change.
// - Each latched event interrupts only when its mode-two enable is set.
// - Entering F7 sets the F7 change flag, marking completed activation.
// - Status reads zero in reset, then 00 or 40 hex by hookswitch.
// - Priority is four bits, reset zero, upper nibble reads zero.
// - Access needs eight echo ones at level 0, two more per level.
// - Level steps to n+1 after a good packet, back after that count.
// - Mode one bits drive B1, B2, F, FA transmit and F8-to-F3 force.
// - Activation request is bit 4 level; its fall is timer expiry.
// - Bit 6 enables receiver and transmitter, reset clear; bit 7 zero.
// - Local loopback ignores line D data and loops processor data back.
// - Line loopback returns received D bits to the line; no own send.
// - Back-off disable keeps sending despite echo mismatch.
// - Multiframe bit 0 enables sync; bits 1 to 3 are interrupt enables.
// - Multiframe bit 4 flags first subframe, bits 5, 6 zero, 7 sync.
// - First subframe is set when first five S bits load the buffer.
// - Sync lost on three bad multiframes, leaving F6/F7, or disable.
// - Hookswitch rejects glitches under 162 ns and debounces 16 ms.
module s_interface_line_ctrl_regs
  import line_ctrl_pkg::*;
#(
  parameter int GLITCH   = GLITCH_CYC,
  parameter int DEBOUNCE = DEBOUNCE_CYC
)
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       resetn,
  // Register port
  input  wire reg_req_s   regReq,
  output logic [7:0]      rdData,
  // Activation state machine
  input  wire logic [2:0] actState,
  output line_ctl_s       lineCtl,
  output logic            timerExpiry,
  // Hookswitch pin
  input  wire logic       hookPin,
  // D channel
  input  wire d_chan_in_s dChan,
  output logic            dAccessOk,
  output logic            dTxHalt,
  output logic            linkRxD,
  output logic            lineTxD,
  output logic            procTxBlock,
  // Multiframe receiver
  input  wire logic       multiFound,
  input  wire logic       multiValid,
  input  wire logic       multiInvalid,
  input  wire logic       sLoad,
  input  wire logic       sFirst,
  output logic            multiSynced,
  output logic [2:0]      multiIrqEn,
  // Interrupt request
  output logic            lineIrq
);

  typedef struct packed {
    logic [7:0] rdData;
    logic [2:0] prevAct;
    logic       f3Chg;
    logic       f7Chg;
    logic       f8Chg;
    logic       hookChg;
    logic [6:0] modeOne;
    logic [6:0] modeTwo;
    logic [3:0] prio;
    logic [4:0] curLevel;
    logic [5:0] oneCount;
    logic       accessOk;
    logic       txHalt;
    logic       timerExp;
    logic [3:0] multiCtl;
    logic       multiFirst;
    logic       multiSync;
    logic [1:0] badCount;
    logic       linkRxD;
    logic       lineTxD;
    logic       irq;
  } ctrl_s;

  ctrl_s      st_r;
  ctrl_s      st_nxt;
  logic       hookLevel;
  logic       hookChange;
  logic       f3Ev;
  logic       f7Ev;
  logic       f8Ev;
  logic       rdStatus;
  logic [5:0] needOnes;

  hook_debounce #(
    .GLITCH   (GLITCH),
    .DEBOUNCE (DEBOUNCE)
  ) u_hook (
    .clock      (clock),
    .resetn     (resetn),
    .hookPin    (hookPin),
    .hookLevel  (hookLevel),
    .hookChange (hookChange)
  );

  assign f3Ev     = (actState == ACT_F3) && (st_r.prevAct != ACT_F3);
  assign f7Ev     = (actState == ACT_F7) != (st_r.prevAct == ACT_F7);
  assign f8Ev     = (actState == ACT_F8) != (st_r.prevAct == ACT_F8);
  assign rdStatus = regReq.rdStb && (regReq.addr == LINE_STATUS_ADDR);
  assign needOnes = ONES_BASE + ONES_STEP * {1'b0, st_r.curLevel};

  always_comb
  begin
    st_nxt          = st_r;
    st_nxt.rdData   = REG_RESET_VAL;
    st_nxt.txHalt   = 1'b0;
    st_nxt.timerExp = 1'b0;
    st_nxt.prevAct  = actState;

    // Register reads, data valid in the following cycle
    if (regReq.rdStb)
    begin
      case (regReq.addr)
        LINE_STATUS_ADDR:
          st_nxt.rdData = {st_r.hookChg, hookLevel, st_r.f8Chg,
                           st_r.f7Chg, st_r.f3Chg, actState};
        D_PRIORITY_ADDR:
          st_nxt.rdData = {4'h0, st_r.prio};
        LINE_MODE1_ADDR:
          st_nxt.rdData = {1'b0, st_r.modeOne};
        LINE_MODE2_ADDR:
          st_nxt.rdData = {1'b0, st_r.modeTwo};
        MULTIFRAME_ADDR:
          st_nxt.rdData = {st_r.multiSync, 2'b00, st_r.multiFirst, st_r.multiCtl};
        default:
          st_nxt.rdData = REG_RESET_VAL;
      endcase
    end

    // Clear on read, then new events set again so none is lost
    if (rdStatus)
    begin
      st_nxt.f3Chg   = 1'b0;
      st_nxt.f7Chg   = 1'b0;
      st_nxt.f8Chg   = 1'b0;
      st_nxt.hookChg = 1'b0;
    end
    if (f3Ev)
      st_nxt.f3Chg = 1'b1;
    if (f7Ev)
      st_nxt.f7Chg = 1'b1;
    if (f8Ev)
      st_nxt.f8Chg = 1'b1;
    if (hookChange)
      st_nxt.hookChg = 1'b1;

    // Register writes
    if (regReq.wrStb)
    begin
      case (regReq.addr)
        D_PRIORITY_ADDR:
        begin
          st_nxt.prio     = regReq.wrData[3:0];
          st_nxt.curLevel = {1'b0, regReq.wrData[3:0]};
        end
        LINE_MODE1_ADDR:
        begin
          st_nxt.modeOne  = regReq.wrData[6:0];
          st_nxt.timerExp = st_r.modeOne[M1_ACT_REQ]
                            && !regReq.wrData[M1_ACT_REQ];
        end
        LINE_MODE2_ADDR:
          st_nxt.modeTwo = regReq.wrData[6:0];
        MULTIFRAME_ADDR:
          st_nxt.multiCtl = regReq.wrData[3:0];
        default:
          st_nxt.rdData = st_nxt.rdData;
      endcase
    end

    // Echo-channel ones counting for D-channel access
    if (dChan.strobe)
    begin
      if (dChan.echoBit && st_r.oneCount != 6'h3f)
        st_nxt.oneCount = st_r.oneCount + 6'h01;
      else if (!dChan.echoBit)
        st_nxt.oneCount = 6'h00;
      // A mismatch stops sending unless back-off is disabled
      if (dChan.txActive && (dChan.echoBit != dChan.txBit)
          && !st_r.modeTwo[M2_NO_BACK])
        st_nxt.txHalt = 1'b1;
    end
    st_nxt.accessOk = (st_nxt.oneCount >= needOnes);

    // Automatic stepping between n and n+1
    if (!(regReq.wrStb && regReq.addr == D_PRIORITY_ADDR))
    begin
      if (dChan.txDone)
        st_nxt.curLevel = {1'b0, st_r.prio} + 5'h01;
      else if ((st_r.curLevel != {1'b0, st_r.prio}) && (st_r.oneCount >= needOnes))
        st_nxt.curLevel = {1'b0, st_r.prio};
    end

    // D-channel loopback paths
    if (st_r.modeTwo[M2_LOC_LOOP])
    begin
      st_nxt.linkRxD = dChan.procTxD;
      st_nxt.lineTxD = 1'b1;
    end
    else if (st_r.modeTwo[M2_LINE_LOOP])
    begin
      st_nxt.linkRxD = dChan.lineRxD;
      st_nxt.lineTxD = dChan.lineRxD;
    end
    else
    begin
      st_nxt.linkRxD = dChan.lineRxD;
      st_nxt.lineTxD = dChan.procTxD;
    end

    // Multiframe first subframe and sync tracking
    if (sLoad)
      st_nxt.multiFirst = sFirst;
    if (!st_nxt.multiCtl[MULTI_ENABLE]
        || (actState != ACT_F6 && actState != ACT_F7))
    begin
      st_nxt.multiSync = 1'b0;
      st_nxt.badCount  = 2'h0;
    end
    else if (!st_r.multiSync)
    begin
      st_nxt.multiSync = multiFound;
      st_nxt.badCount  = 2'h0;
    end
    else if (multiInvalid)
    begin
      st_nxt.badCount = st_r.badCount + 2'h1;
      if (st_r.badCount + 2'h1 == MULTI_LOST_COUNT)
      begin
        st_nxt.multiSync = 1'b0;
        st_nxt.badCount  = 2'h0;
      end
    end
    else if (multiValid)
      st_nxt.badCount = 2'h0;

    // Enabled latched events form the interrupt request
    st_nxt.irq = (st_nxt.f3Chg && st_nxt.modeTwo[M2_IE_F3])
                 || (st_nxt.f7Chg && st_nxt.modeTwo[M2_IE_F7])
                 || (st_nxt.f8Chg && st_nxt.modeTwo[M2_IE_F8])
                 || (st_nxt.hookChg && st_nxt.modeTwo[M2_IE_HOOK]);
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r         <= '0;
      st_r.prevAct <= ACT_F2;
    end
    else
      st_r <= st_nxt;
  end

  assign rdData              = st_r.rdData;
  assign lineCtl.b1TxEn      = st_r.modeOne[M1_B1_TX];
  assign lineCtl.b2TxEn      = st_r.modeOne[M1_B2_TX];
  assign lineCtl.fTxDis      = st_r.modeOne[M1_F_DIS];
  assign lineCtl.faTxDis     = st_r.modeOne[M1_FA_DIS];
  assign lineCtl.actRequest  = st_r.modeOne[M1_ACT_REQ];
  assign lineCtl.goF8ToF3    = st_r.modeOne[M1_F8_F3];
  assign lineCtl.lineEnable  = st_r.modeOne[M1_ENABLE];
  assign timerExpiry         = st_r.timerExp;
  assign dAccessOk           = st_r.accessOk;
  assign dTxHalt             = st_r.txHalt;
  assign linkRxD             = st_r.linkRxD;
  assign lineTxD             = st_r.lineTxD;
  assign procTxBlock         = st_r.modeTwo[M2_LINE_LOOP];
  assign multiSynced         = st_r.multiSync;
  assign multiIrqEn          = st_r.multiCtl[3:1];
  assign lineIrq             = st_r.irq;

  sequence s_status_read;
    regReq.rdStb && (regReq.addr == LINE_STATUS_ADDR);
  endsequence

  sequence s_eighth_one;
    dChan.strobe && dChan.echoBit && (st_r.oneCount == 6'h07);
  endsequence

  property p_state_field;
    @(posedge clock) disable iff (!resetn)
      s_status_read |=> (rdData[2:0] == $past(actState));
  endproperty
  a_state_field: assert property (p_state_field)
    else $error("status state field wrong");

  property p_read_clears;
    @(posedge clock) disable iff (!resetn)
      s_status_read ##0 (!f3Ev && !f7Ev && !f8Ev && !hookChange)
      |=> !st_r.f3Chg && !st_r.f7Chg && !st_r.f8Chg && !st_r.hookChg;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("status flags not cleared by read");

  property p_event_kept;
    @(posedge clock) disable iff (!resetn)
      s_status_read ##0 f3Ev |=> st_r.f3Chg && (rdData[ST_F3_CHG] == $past(st_r.f3Chg));
  endproperty
  a_event_kept: assert property (p_event_kept)
    else $error("event lost during clearing read");

  property p_f7_entry;
    @(posedge clock) disable iff (!resetn)
      (actState == ACT_F7) && (st_r.prevAct != ACT_F7) |=> st_r.f7Chg;
  endproperty
  a_f7_entry: assert property (p_f7_entry)
    else $error("F7 entry not flagged");

  property p_irq_gate;
    @(posedge clock) disable iff (!resetn)
      (st_r.modeTwo[6:3] == 4'h0) |-> !lineIrq;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt raised while all enables clear");

  property p_reset_zero;
    @(posedge clock) !resetn |-> (rdData == REG_RESET_VAL);
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("status not zero in reset");

  property p_prio_read;
    @(posedge clock) disable iff (!resetn)
      (regReq.wrStb && regReq.addr == D_PRIORITY_ADDR)
      ##1 (regReq.rdStb && regReq.addr == D_PRIORITY_ADDR)
      |=> (rdData == {4'h0, $past(regReq.wrData[3:0], 2)});
  endproperty
  a_prio_read: assert property (p_prio_read)
    else $error("priority readback wrong");

  property p_level0_access;
    @(posedge clock) disable iff (!resetn)
      (st_r.curLevel == 5'h00) ##0 s_eighth_one |=> dAccessOk;
  endproperty
  a_level0_access: assert property (p_level0_access)
    else $error("no access after eight ones at level 0");

  property p_step_up;
    @(posedge clock) disable iff (!resetn)
      dChan.txDone && !regReq.wrStb |=> (st_r.curLevel == $past(st_r.prio) + 5'h01);
  endproperty
  a_step_up: assert property (p_step_up)
    else $error("priority did not step up");

  property p_timer_expiry;
    @(posedge clock) disable iff (!resetn)
      lineCtl.actRequest && regReq.wrStb && (regReq.addr == LINE_MODE1_ADDR)
      && !regReq.wrData[M1_ACT_REQ] |=> timerExpiry ##1 !timerExpiry;
  endproperty
  a_timer_expiry: assert property (p_timer_expiry)
    else $error("timer expiry pulse missing");

  property p_backoff;
    @(posedge clock) disable iff (!resetn)
      dChan.strobe && dChan.txActive && (dChan.echoBit != dChan.txBit)
      |=> (dTxHalt == !$past(st_r.modeTwo[M2_NO_BACK]));
  endproperty
  a_backoff: assert property (p_backoff)
    else $error("back-off halt wrong");

  property p_sync_lost;
    @(posedge clock) disable iff (!resetn)
      (actState != ACT_F6 && actState != ACT_F7) |=> !multiSynced;
  endproperty
  a_sync_lost: assert property (p_sync_lost)
    else $error("multiframe sync held outside F6/F7");

endmodule : s_interface_line_ctrl_regs

// [verification/nt_model.sv]
/*
  Network terminator stand-in: activation state, echo slots, line D bits.
  Assumes the terminal's line controls and D transmit bit on the same clock.
*/
module nt_model
  import line_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic      clock,
  input  wire logic      resetn,
  // Terminal side
  input  wire line_ctl_s lineCtl,
  input  wire logic      txBit,
  input  wire logic      badEcho,
  input  wire logic      slow,
  // Line side
  output logic [2:0]     actState,
  output logic           strobe,
  output logic           echoBit,
  output logic           lineRxD
);
  logic [1:0] slotCnt;
  logic [4:0] waitCnt;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      {actState, slotCnt, waitCnt} <= '0;
      {strobe, echoBit, lineRxD}   <= '0;
    end
    else
    begin
      slotCnt <= slotCnt + 2'h1;
      strobe  <= (slotCnt == 2'h3);
      // Echo repeats the sent bit unless told to corrupt it
      echoBit <= txBit ^ badEcho;
      lineRxD <= lineRxD ^ (slotCnt == 2'h3);
      waitCnt <= (waitCnt == 5'h0) ? waitCnt : waitCnt - 5'h1;
      if (!lineCtl.lineEnable)
        actState <= ACT_F2;
      else if (actState == ACT_F2)
        actState <= ACT_F3;
      // Activation proceeds only while F and FA framing is sent
      else if (lineCtl.actRequest && !lineCtl.fTxDis && !lineCtl.faTxDis
               && waitCnt == 5'h0 && actState != ACT_F7)
      begin
        actState <= (actState == ACT_F3) ? ACT_F6 : ACT_F7;
        waitCnt  <= slow ? 5'h1f : 5'h02;
      end
    end
  end
endmodule : nt_model

// [verification/tb_top.sv]
/*
  Self-checking bench of the line control register bank.
  Assumes the terminator model drives activation state and echo slots.
*/
module tb_top
  import line_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic       clock = 1'b0;
  logic       resetn = 1'b1;
  reg_req_s   req = '0;
  logic [4:0] multiIn = '0;
  logic       hookPin = 1'b0;
  logic       txBit = 1'b1;
  logic       txActive = 1'b0;
  logic       txDone = 1'b0;
  logic       procTxD = 1'b1;
  logic       badEcho = 1'b0;
  logic [7:0] rdData;
  logic [2:0] actState, multiIrqEn;
  line_ctl_s  lineCtl;
  d_chan_in_s dChan;
  logic       timerExpiry, dAccessOk, dTxHalt, linkRxD, lineTxD, procTxBlock;
  logic       multiSynced, lineIrq, strobe, echoBit, lineRxD;
  int         errCount = 0;
  int         checks = 0;

  always #10 clock = ~clock;
  assign dChan = {strobe, echoBit, txBit, txActive, txDone, lineRxD, procTxD};

  s_interface_line_ctrl_regs #(.GLITCH(2), .DEBOUNCE(8)) DUT (
    .clock(clock), .resetn(resetn), .regReq(req), .rdData(rdData),
    .actState(actState), .lineCtl(lineCtl), .timerExpiry(timerExpiry),
    .hookPin(hookPin), .dChan(dChan), .dAccessOk(dAccessOk), .dTxHalt(dTxHalt),
    .linkRxD(linkRxD), .lineTxD(lineTxD), .procTxBlock(procTxBlock),
    .multiFound(multiIn[4]), .multiValid(multiIn[3]), .multiInvalid(multiIn[2]),
    .sLoad(multiIn[1]), .sFirst(multiIn[0]), .multiSynced(multiSynced),
    .multiIrqEn(multiIrqEn), .lineIrq(lineIrq));

  nt_model NT (
    .clock(clock), .resetn(resetn), .lineCtl(lineCtl), .txBit(txBit),
    .badEcho(badEcho), .slow(1'b1), .actState(actState), .strobe(strobe),
    .echoBit(echoBit), .lineRxD(lineRxD));

  task automatic end_sim();
    $display("Checks %0d, errors %0d", checks, errCount);
    if (errCount == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      errCount++;
      $display("Error at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chkb(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      errCount++;
      $display("Error at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask : chkb

  task automatic fail_wait();
    errCount++;
    $display("Error at %0t: wait ran out", $time);
    end_sim();
  endtask : fail_wait

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock) req <= '{a, d, 1'b1, 1'b0};
    @(posedge clock) req.wrStb <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock) req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock) req.rdStb <= 1'b0;
    #1;
    chk(rdData, exp);
  endtask : rd

  // Write, then read back in the very next cycle
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
    @(posedge clock) req <= '{a, d, 1'b1, 1'b0};
    @(posedge clock) req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock) req.rdStb <= 1'b0;
    #1;
    chk(rdData, exp);
  endtask : wr_rd

  task automatic multi_pulse(input logic [4:0] v);
    @(posedge clock) multiIn <= v;
    @(posedge clock) multiIn <= 5'h00;
    cyc(2);
  endtask : multi_pulse

  task automatic wait_state(input logic [2:0] s);
    int i;
    for (i = 0; i < 200 && actState !== s; i++)
      @(posedge clock);
    if (actState !== s)
      fail_wait();
    cyc(2);
  endtask : wait_state

  // Returns just after the edge that took a slot, while its one-cycle answer stands
  task automatic slot();
    int i;
    @(posedge clock);
    for (i = 0; i < 8 && strobe !== 1'b1; i++)
      @(posedge clock);
    if (strobe !== 1'b1)
      fail_wait();
    #1;
  endtask : slot

  // Drives zero over two slots, then a run of ones; access only at the last one
  task automatic run_ones(input int need);
    int k;
    @(posedge clock) txBit <= 1'b0;
    slot();
    slot();
    @(posedge clock) txBit <= 1'b1;
    for (k = 1; k <= need; k++)
    begin
      slot();
      chkb(dAccessOk, k == need);
    end
  endtask : run_ones

  task automatic hook_test();
    @(posedge clock) hookPin <= 1'b1;
    cyc(40);
    chkb(lineIrq, 1'b0);
    wr(LINE_MODE2_ADDR, 8'h78);
    cyc(2);
    chkb(lineIrq, 1'b1);
    rd(LINE_STATUS_ADDR, 8'hc0);
    rd(LINE_STATUS_ADDR, 8'h40);
    @(posedge clock) hookPin <= 1'b0;
    @(posedge clock) hookPin <= 1'b1;
    cyc(40);
    rd(LINE_STATUS_ADDR, 8'h40);
    chkb(lineIrq, 1'b0);
  endtask : hook_test

  task automatic activation_test();
    wr(LINE_MODE1_ADDR, 8'h40);
    chkb(lineCtl.lineEnable, 1'b1);
    // This read is taken on the edge where the F3 change flag is set
    rd(LINE_STATUS_ADDR, 8'h41);
    wait_state(ACT_F3);
    rd(LINE_STATUS_ADDR, 8'h49);
    // Receiver enabled for at least 250 us before requesting activation
    cyc(12500);
    wr(LINE_MODE1_ADDR, 8'h50);
    chkb(lineCtl.actRequest, 1'b1);
    wait_state(ACT_F7);
    chkb(lineIrq, 1'b1);
    rd(LINE_STATUS_ADDR, 8'h55);
    rd(LINE_STATUS_ADDR, 8'h45);
    wr(LINE_MODE1_ADDR, 8'h40);
    chkb(timerExpiry, 1'b1);
    cyc(1);
    chkb(timerExpiry, 1'b0);
  endtask : activation_test

  task automatic multiframe_test();
    wr(MULTIFRAME_ADDR, 8'hff);
    rd(MULTIFRAME_ADDR, 8'h0f);
    chk({5'h00, multiIrqEn}, 8'h07);
    multi_pulse(5'h10);
    chkb(multiSynced, 1'b1);
    multi_pulse(5'h03);
    rd(MULTIFRAME_ADDR, 8'h9f);
    repeat (3) multi_pulse(5'h04);
    rd(MULTIFRAME_ADDR, 8'h1f);
  endtask : multiframe_test

  task automatic dchan_test();
    run_ones(8);
    @(posedge clock) txDone <= 1'b1;
    @(posedge clock) txDone <= 1'b0;
    run_ones(10);
    run_ones(8);
    @(posedge clock) txActive <= 1'b1;
    badEcho <= 1'b1;
    slot();
    slot();
    chkb(dTxHalt, 1'b1);
    wr(LINE_MODE2_ADDR, 8'h04);
    slot();
    chkb(dTxHalt, 1'b0);
    @(posedge clock) txActive <= 1'b0;
    badEcho <= 1'b0;
    wr(LINE_MODE2_ADDR, 8'h01);
    @(posedge clock) procTxD <= 1'b0;
    cyc(3);
    chkb(linkRxD, 1'b0);
    chkb(lineTxD, 1'b1);
    @(posedge clock) procTxD <= 1'b1;
    cyc(3);
    chkb(linkRxD, 1'b1);
    wr(LINE_MODE2_ADDR, 8'h02);
    cyc(2);
    chkb(procTxBlock, 1'b1);
  endtask : dchan_test

  initial
  begin
    // Asserted at time zero so the asynchronous reset sees a falling edge
    resetn <= 1'b0;
    repeat (10) @(posedge clock);
    chk(rdData, 8'h00);
    resetn <= 1'b1;
    cyc(8);
    rd(LINE_STATUS_ADDR, 8'h00);
    rd(D_PRIORITY_ADDR, 8'h00);
    rd(LINE_MODE1_ADDR, 8'h00);
    wr_rd(D_PRIORITY_ADDR, 8'hff, 8'h0f);
    wr(D_PRIORITY_ADDR, 8'h00);
    wr(8'ha5, 8'hff);
    rd(8'ha5, 8'h00);
    cyc(1);
    chk(rdData, 8'h00);
    hook_test();
    activation_test();
    multiframe_test();
    dchan_test();
    wr(LINE_MODE1_ADDR, 8'h7f);
    rd(LINE_MODE1_ADDR, 8'h7f);
    chk({1'b0, lineCtl}, 8'h7f);
    chkb(lineCtl.b1TxEn, 1'b1);
    chkb(lineCtl.goF8ToF3, 1'b1);
    end_sim();
  end
endmodule : tb_top
